// ### cri_top.sv
// indirect access port to the usb device core registers, axi4-lite slave
//
// Summary of operation
// - writing request bit starts a core read
// - read done: request self clears, done flag set
// - request bit reads 1 during core write
// - abort bit stops access, clears request bit
// - abort bit clears itself after abort completes
// - address field bits 9:2 select core word
// - 16-bit result lands in value bits 15:0
`default_nettype none
module cri_top import cri_pkg::*; (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite slave
  input  wire logic [CRI_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [CRI_AXI_AW-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // core register port, same clock
  output cri_core_req_s              core_req,
  input  wire cri_core_rsp_s         core_rsp,
  output logic                       irq
);
  // ==========================================================
  // bus side state
  logic                  awready_q, awready_d;
  logic                  aw_vld_q, aw_vld_d;
  logic [CRI_AXI_AW-1:0] awaddr_q, awaddr_d;
  logic                  wready_q, wready_d;
  logic                  w_vld_q, w_vld_d;
  logic [31:0]           wdata_q, wdata_d;
  logic [3:0]            wstrb_q, wstrb_d;
  logic                  bvalid_q, bvalid_d;
  logic [1:0]            bresp_q, bresp_d;
  logic                  arready_q, arready_d;
  logic                  rvalid_q, rvalid_d;
  logic [31:0]           rdata_q, rdata_d;
  logic [1:0]            rresp_q, rresp_d;

  // ==========================================================
  // engine state
  cri_state_e            state_q, state_d;
  logic [7:0]            caddr_q, caddr_d;
  logic [15:0]           cwdata_q, cwdata_d;
  logic [15:0]           value_q, value_d;
  cri_core_req_s         creq_q, creq_d;

  // strobes and events
  logic                  do_wr;
  logic                  ar_take;
  logic                  wr_map;
  logic [31:0]           wr_word;
  logic [CRI_EVT_W-1:0]  evt;
  logic                  sts_rd;
  logic                  mask_wr;
  logic [CRI_EVT_W-1:0]  sts;
  logic [CRI_EVT_W-1:0]  msk;
  logic                  irq_q;

  // merge the write data into a word under the byte strobes
  function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // current contents of the request register as software sees it
  function automatic logic [31:0] req_word(input cri_state_e st,
                                           input logic [7:0] ad);
    logic [31:0] res;
    res = CRI_REQ_RESET;
    res[CRI_BIT_REQ]   = (st == CRI_READ) || (st == CRI_WRITE);
    res[CRI_BIT_ABORT] = (st == CRI_ABORT);
    res[CRI_ADDR_HI:CRI_ADDR_LO] = ad;
    return res;
  endfunction

  // ==========================================================
  // write channel: address and data taken in either order
  always_comb begin
    do_wr    = aw_vld_q && w_vld_q && !bvalid_q;
    aw_vld_d = aw_vld_q ? !do_wr : (s_axi_awvalid && awready_q);
    w_vld_d  = w_vld_q ? !do_wr : (s_axi_wvalid && wready_q);
    awaddr_d = (s_axi_awvalid && awready_q) ? s_axi_awaddr : awaddr_q;
    wdata_d  = (s_axi_wvalid && wready_q) ? s_axi_wdata : wdata_q;
    wstrb_d  = (s_axi_wvalid && wready_q) ? s_axi_wstrb : wstrb_q;
    awready_d = !aw_vld_d;
    wready_d  = !w_vld_d;
    wr_map   = (awaddr_q == CRI_OFF_REQ) || (awaddr_q == CRI_OFF_INT_MASK)
            || (awaddr_q == CRI_OFF_WR_DATA) || (awaddr_q == CRI_OFF_VALUE)
            || (awaddr_q == CRI_OFF_INT_STS);
    bvalid_d = bvalid_q ? !s_axi_bready : do_wr;
    bresp_d  = do_wr ? (wr_map ? CRI_RESP_OKAY : CRI_RESP_SLVERR) : bresp_q;
  end

  // ==========================================================
  // read channel: one answer outstanding, data one edge after address
  always_comb begin
    ar_take   = s_axi_arvalid && arready_q;
    rvalid_d  = rvalid_q ? !s_axi_rready : ar_take;
    arready_d = !rvalid_d;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    sts_rd    = 1'b0;
    if (ar_take) begin
      rresp_d = CRI_RESP_OKAY;
      unique case (s_axi_araddr)
        CRI_OFF_REQ:      rdata_d = req_word(state_q, caddr_q);
        CRI_OFF_VALUE:    rdata_d = {16'h0000, value_q};
        CRI_OFF_INT_STS: begin
          rdata_d = {{(32-CRI_EVT_W){1'b0}}, sts};
          sts_rd  = 1'b1;
        end
        CRI_OFF_INT_MASK: rdata_d = {{(32-CRI_EVT_W){1'b0}}, msk};
        CRI_OFF_WR_DATA:  rdata_d = {16'h0000, cwdata_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = CRI_RESP_SLVERR;
        end
      endcase
    end
  end

  // ==========================================================
  // access engine; unused bits read zero, which is harmless
  always_comb begin
    state_d  = state_q;
    caddr_d  = caddr_q;
    cwdata_d = cwdata_q;
    value_d  = value_q;
    creq_d   = creq_q;
    evt      = '0;
    mask_wr  = 1'b0;
    wr_word  = 32'h0000_0000;
    unique case (state_q)
      CRI_READ: begin
        if (core_rsp.ack) begin
          value_d                = core_rsp.rdata;
          creq_d.valid           = 1'b0;
          state_d                = CRI_IDLE;
          evt[CRI_EVT_RD_DONE]   = 1'b1;
        end
      end
      CRI_WRITE: begin
        if (core_rsp.ack) begin
          creq_d.valid           = 1'b0;
          state_d                = CRI_IDLE;
          evt[CRI_EVT_WR_DONE]   = 1'b1;
        end
      end
      CRI_ABORT: begin
        // request already dropped; abort bit falls back now
        state_d                  = CRI_IDLE;
        evt[CRI_EVT_ABORTED]     = 1'b1;
      end
      CRI_IDLE: ;
    endcase
    if (do_wr) begin
      unique case (awaddr_q)
        CRI_OFF_REQ: begin
          wr_word = merge_strb(req_word(state_q, caddr_q), wdata_q, wstrb_q);
          if (wr_word[CRI_BIT_ABORT]) begin
            // abort beats everything, data left as-is
            creq_d.valid = 1'b0;
            state_d      = CRI_ABORT;
          end else if (state_q == CRI_IDLE) begin
            // a busy engine ignores new requests
            caddr_d = wr_word[CRI_ADDR_HI:CRI_ADDR_LO];
            if (wr_word[CRI_BIT_REQ]) begin
              creq_d  = '{valid: 1'b1, we: 1'b0, addr: caddr_d,
                          wdata: 16'h0000};
              state_d = CRI_READ;
            end
          end
        end
        CRI_OFF_WR_DATA: begin
          if (state_q == CRI_IDLE) begin
            wr_word  = merge_strb({16'h0000, cwdata_q}, wdata_q, wstrb_q);
            cwdata_d = wr_word[15:0];
            creq_d   = '{valid: 1'b1, we: 1'b1, addr: caddr_q,
                         wdata: cwdata_d};
            state_d  = CRI_WRITE;
          end
        end
        CRI_OFF_INT_MASK: mask_wr = wstrb_q[0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_vld_q  <= 1'b0;
      awaddr_q  <= '0;
      wready_q  <= 1'b1;
      w_vld_q   <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= CRI_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= CRI_RESP_OKAY;
      state_q   <= CRI_IDLE;
      caddr_q   <= 8'h00;
      cwdata_q  <= 16'h0000;
      value_q   <= CRI_VALUE_RESET[15:0];
      creq_q    <= '0;
    end else begin
      awready_q <= awready_d;
      aw_vld_q  <= aw_vld_d;
      awaddr_q  <= awaddr_d;
      wready_q  <= wready_d;
      w_vld_q   <= w_vld_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      state_q   <= state_d;
      caddr_q   <= caddr_d;
      cwdata_q  <= cwdata_d;
      value_q   <= value_d;
      creq_q    <= creq_d;
    end
  end

  // ==========================================================
  // interrupt status, mask and line
  cri_evt_irq #(
    .W          (CRI_EVT_W)
  ) u_evt_irq (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .evt        (evt),
    .rd_clr     (sts_rd),
    .mask_wr    (mask_wr),
    .mask_wdata (wdata_q[CRI_EVT_W-1:0]),
    .status_q   (sts),
    .mask_q     (msk),
    .irq_q      (irq_q)
  );

  // outputs, all straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign core_req      = creq_q;
  assign irq           = irq_q;
endmodule // cri_top
`default_nettype wire

// ### cri_pkg.sv
// package of constants and types for the core register indirect access block
`default_nettype none
package cri_pkg;
  // ==========================================================
  // register map, byte addresses
  localparam int          CRI_AXI_AW        = 12;
  localparam logic [11:0] CRI_OFF_REQ       = 12'h000;
  localparam logic [11:0] CRI_OFF_VALUE     = 12'h004;
  localparam logic [11:0] CRI_OFF_INT_STS   = 12'h008;
  localparam logic [11:0] CRI_OFF_INT_MASK  = 12'h00C;
  localparam logic [11:0] CRI_OFF_WR_DATA   = 12'h010;

  // ==========================================================
  // request register fields
  localparam int          CRI_BIT_REQ       = 31;
  localparam int          CRI_BIT_ABORT     = 30;
  localparam int          CRI_ADDR_HI       = 9;
  localparam int          CRI_ADDR_LO       = 2;
  localparam int          CRI_CADDR_W       = 8;
  localparam int          CRI_CDATA_W       = 16;
  localparam logic [31:0] CRI_REQ_RESET     = 32'h0000_0000;
  localparam logic [31:0] CRI_VALUE_RESET   = 32'h0000_0000;

  // ==========================================================
  // interrupt status bits
  localparam int          CRI_EVT_W         = 3;
  localparam int          CRI_EVT_RD_DONE   = 0;
  localparam int          CRI_EVT_WR_DONE   = 1;
  localparam int          CRI_EVT_ABORTED   = 2;
  localparam logic [2:0]  CRI_MASK_RESET    = 3'h0;

  // ==========================================================
  // bus answers
  localparam logic [1:0]  CRI_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  CRI_RESP_SLVERR   = 2'h2;

  // access engine states
  typedef enum logic [1:0] {
    CRI_IDLE  = 2'b00,
    CRI_READ  = 2'b01,
    CRI_WRITE = 2'b10,
    CRI_ABORT = 2'b11
  } cri_state_e;

  // request toward the core register port
  typedef struct packed {
    logic        valid;
    logic        we;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } cri_core_req_s;

  // answer from the core register port
  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } cri_core_rsp_s;
endpackage
`default_nettype wire

// ### cri_evt_irq.sv
// sticky event status with read clear, mask and one level interrupt
`default_nettype none
module cri_evt_irq import cri_pkg::*; #(
  parameter int W = 3
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] evt,
  input  wire logic         rd_clr,
  input  wire logic         mask_wr,
  input  wire logic [W-1:0] mask_wdata,
  output logic      [W-1:0] status_q,
  output logic      [W-1:0] mask_q,
  output logic              irq_q
);
  logic [W-1:0] status_d;
  logic [W-1:0] mask_d;
  logic         irq_d;

  // ==========================================================
  // next state: a set in the clearing cycle survives the clear
  always_comb begin
    status_d = (rd_clr ? '0 : status_q) | evt;
    mask_d   = mask_wr ? mask_wdata : mask_q;
    irq_d    = |(status_d & mask_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
      mask_q   <= W'(CRI_MASK_RESET);
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
      irq_q    <= irq_d;
    end
  end
endmodule // cri_evt_irq
`default_nettype wire

// ### cri_top_monitor.sv
// port timing checker for the core register indirect access block
`default_nettype none
module cri_top_monitor import cri_pkg::*; (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic [31:0]   s_axi_wdata,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire cri_core_req_s core_req,
  input wire cri_core_rsp_s core_rsp
);
  // ==========================================================
  // last data word taken, it carries the address field
  logic [31:0] last_wdata_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) last_wdata_q <= '0;
    else if (s_axi_wvalid && s_axi_wready) last_wdata_q <= s_axi_wdata;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // steps of a register write and of a core access
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_core_start;
    $rose(core_req.valid);
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_core_start: assert property (s_core_start |-> $rose(s_axi_bvalid))
    else $error("core access without register write");
  a_addr_field: assert property (s_core_start ##0 !core_req.we |->
    core_req.addr == last_wdata_q[9:2]) else $error("core address wrong");
  a_ack_ends: assert property (core_req.valid && core_rsp.ack |=> !core_req.valid)
    else $error("request stays after answer");
  // an abort arrives through the data channel, so only quiet cycles must hold
  a_req_steady: assert property (core_req.valid && !core_rsp.ack && !s_axi_wvalid
    && !$past(s_axi_wvalid) |=> $stable(core_req)) else $error("core request moved");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // cri_top_monitor
bind cri_top cri_top_monitor mon_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .core_req,
  .core_rsp);
`default_nettype wire

// ### cri_core_model.sv
// behavioural model of the usb device core register port
`default_nettype none
module cri_core_model import cri_pkg::*; (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire cri_core_req_s core_req,
  input  wire logic [7:0]    delay,
  output var cri_core_rsp_s  core_rsp,
  output var logic [23:0]    last_wr
);
  logic [7:0] cnt_q;
  // answer after delay cycles; data toggles between answers so none is stale
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      core_rsp <= '0;
      last_wr <= '0;
    end else begin
      core_rsp.ack <= 1'b0;
      core_rsp.rdata <= ~core_rsp.rdata;
      if (core_req.valid && !core_rsp.ack) begin
        if (cnt_q == delay) begin
          cnt_q <= '0;
          core_rsp.ack <= 1'b1;
          core_rsp.rdata <= {core_req.addr, ~core_req.addr};
          if (core_req.we) last_wr <= {core_req.addr, core_req.wdata};
        end else cnt_q <= cnt_q + 8'h01;
      end else cnt_q <= '0;
    end
  end
endmodule // cri_core_model
`default_nettype wire

// ### cri_top_tb.sv
// self-checking testbench for the core register indirect access block
`default_nettype none
module cri_top_tb import cri_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  delay;
  logic [23:0] last_wr;
  cri_core_req_s core_req;
  cri_core_rsp_s core_rsp;
  int errors, total_checks;
  cri_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_req, .core_rsp, .irq);
  cri_core_model core_u (.aclk, .aresetn, .core_req, .delay, .core_rsp, .last_wr);
  always #2.5 aclk = ~aclk;
  // ==========================================================
  // compare, bus cycles and verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin ad = 1; s_axi_awvalid <= 1'b0; end
      if (!dd && s_axi_wready) begin dd = 1; s_axi_wvalid <= 1'b0; end
    end
    // late ready lets the answer wait a cycle
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    // the answer is taken only at an edge that sees bready high
    do @(posedge aclk); while (!s_axi_bvalid);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    // data taken at the edge where rvalid and rready are both high
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
  endtask
  // polling the request register is safe while busy; besides mask writes, an abort write there is the only write a busy engine obeys
  task automatic wait_idle();
    for (int i = 0; i < 100 && (i == 0 || v[CRI_BIT_REQ]); i++) rd(CRI_OFF_REQ, v, CRI_RESP_OKAY);
    chk("idle", 32'h0, {31'h0, v[CRI_BIT_REQ]});
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(CRI_OFF_REQ, v, CRI_RESP_OKAY); chk("req reset", CRI_REQ_RESET, v);
    rd(CRI_OFF_VALUE, v, CRI_RESP_OKAY); chk("value reset", CRI_VALUE_RESET, v);
  endtask
  task automatic t_read();
    wr(CRI_OFF_INT_MASK, 32'h1, CRI_RESP_OKAY);
    wr(CRI_OFF_REQ, 32'h8000_0200, CRI_RESP_OKAY);
    rd(CRI_OFF_REQ, v, CRI_RESP_OKAY); chk("busy", 32'h8000_0200, v);
    wait_idle();
    chk("req done", 32'h0000_0200, v);
    rd(CRI_OFF_VALUE, v, CRI_RESP_OKAY); chk("value", 32'h0000_807F, v);
    chk("irq set", 32'h1, {31'h0, irq});
    rd(CRI_OFF_INT_STS, v, CRI_RESP_OKAY); chk("done flag", 32'h1, v);
    repeat (2) @(posedge aclk);
    chk("irq clear", 32'h0, {31'h0, irq});
  endtask
  task automatic t_write();
    wr(CRI_OFF_REQ, 32'h0000_0334, CRI_RESP_OKAY);
    wr(CRI_OFF_WR_DATA, 32'h0000_1234, CRI_RESP_OKAY);
    rd(CRI_OFF_REQ, v, CRI_RESP_OKAY); chk("write busy", 32'h8000_0334, v);
    wait_idle();
    chk("core write", 32'h00CD_1234, {8'h0, last_wr});
    chk("masked irq", 32'h0, {31'h0, irq});
    rd(CRI_OFF_INT_STS, v, CRI_RESP_OKAY); chk("write flag", 32'h2, v);
    rd(CRI_OFF_WR_DATA, v, CRI_RESP_OKAY); chk("write data", 32'h1234, v);
  endtask
  task automatic t_abort();
    delay <= 8'd200;
    wr(CRI_OFF_REQ, 32'h8000_0204, CRI_RESP_OKAY);
    wr(CRI_OFF_REQ, 32'h4000_0000, CRI_RESP_OKAY);
    // address field survives the abort, both control bits fall back
    rd(CRI_OFF_REQ, v, CRI_RESP_OKAY); chk("aborted", 32'h0000_0204, v);
    chk("core idle", 32'h0, {31'h0, core_req.valid});
    rd(CRI_OFF_INT_STS, v, CRI_RESP_OKAY); chk("abort flag", 32'h4, v);
    delay <= 8'd20;
  endtask
  task automatic t_unmapped();
    wr(12'h020, 32'hFFFF_FFFF, CRI_RESP_SLVERR);
    rd(12'h020, v, CRI_RESP_SLVERR); chk("unmapped", 32'h0, v);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    {aclk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, v} = '0;
    s_axi_wstrb = 4'hF;
    delay = 8'd20;
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_read();
    t_write();
    t_abort();
    t_unmapped();
    results();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    results();
  end
endmodule // cri_top_tb
`default_nettype wire
